/* File: logic/otv_top.sv */
// Oscillation monitor channels, two-of-four voters and APB registers.
//
// Chosen here: the register addresses and register access over APB.
`default_nettype none
module otv_top import otv_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Detector and plant inputs.
  input wire logic [NCT*NDET-1:0][DW-1:0] det_i,
  input wire logic [NCH-1:0][7:0] stp_i,
  input wire logic [NCH-1:0][7:0] flow_i,
  input wire logic [NCH-1:0] apm_trip_i,
  // Voter outputs and indicators.
  output logic [NCH-1:0] trip_n_o,
  output logic [NCH-1:0] half_trip_o,
  output otv_chan_stat_t [NCH-1:0] local_o,
  output otv_chan_stat_t [NCH-1:0] panel_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic run_q;
  logic [NCH-1:0] byp_q;
  logic [15:0] irq_stat_q, irq_mask_q, ev_set;
  otv_sp_t trip_sp_q, alm_sp_q;
  logic [7:0] min_cell_q;
  logic [NCT*NDET-1:0] det_map_q, det_byp_q;
  logic tick_q;
  logic [NCH-1:0] ctrip_q, inop_q, pre_q, en_q;
  logic [NCH-1:0] trip_n_q, half_q;
  otv_chan_stat_t [NCH-1:0] local_q, panel_q;
  logic irq_q;
  logic wr_en;

  // Maps an address to a register number; 15 marks an unmapped one.
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    unique case (a)
      OFS_CTRL: reg_sel = 4'h0;
      OFS_STAT: reg_sel = 4'h1;
      OFS_IRQ: reg_sel = 4'h2;
      OFS_MASK: reg_sel = 4'h3;
      OFS_TRIPSP: reg_sel = 4'h4;
      OFS_ALMSP: reg_sel = 4'h5;
      OFS_MINCELL: reg_sel = 4'h6;
      OFS_DETMAP: reg_sel = 4'h7;
      OFS_DETBYP: reg_sel = 4'h8;
      default: reg_sel = 4'hF;
    endcase
  endfunction

  assign wr_en = psel_i & penable_i & pready_q & pwrite_i;

  // One wait state: the answer is ready in the second access cycle.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel_i & penable_i & ~pready_q;
      pslverr_q <= psel_i & penable_i & ~pready_q &
                   (reg_sel(paddr_i) == 4'hF);
      prdata_q <= 32'h00000000;
      if (psel_i & penable_i & ~pready_q & ~pwrite_i) begin
        unique case (reg_sel(paddr_i))
          4'h0: prdata_q <= {24'h000000, byp_q, 3'h0, run_q};
          4'h1: prdata_q <= {8'h00, ~trip_n_q, half_q, en_q, pre_q,
                             inop_q, ctrip_q};
          4'h2: prdata_q <= {16'h0000, irq_stat_q};
          4'h3: prdata_q <= {16'h0000, irq_mask_q};
          4'h4: prdata_q <= {8'h00, trip_sp_q};
          4'h5: prdata_q <= {8'h00, alm_sp_q};
          4'h6: prdata_q <= {24'h000000, min_cell_q};
          4'h7: prdata_q <= {8'h00, det_map_q};
          4'h8: prdata_q <= {8'h00, det_byp_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Setup data is loaded by software whatever the state of the run bit.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_q <= 1'b0;
      byp_q <= 4'h0;
      irq_mask_q <= 16'h0000;
      trip_sp_q <= SP_RST;
      alm_sp_q <= SP_RST;
      min_cell_q <= MINCELL_RST;
      det_map_q <= DETMAP_RST;
      det_byp_q <= DETMAP_RST;
    end else if (wr_en) begin
      unique case (reg_sel(paddr_i))
        4'h0: begin
          run_q <= pwdata_i[CTRL_RUN];
          byp_q <= pwdata_i[CTRL_BYP +: NCH];
        end
        4'h3: irq_mask_q <= pwdata_i[15:0];
        4'h4: trip_sp_q <= pwdata_i[23:0];
        4'h5: alm_sp_q <= pwdata_i[23:0];
        4'h6: min_cell_q <= pwdata_i[7:0];
        4'h7: det_map_q <= pwdata_i[23:0];
        4'h8: det_byp_q <= pwdata_i[23:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Processing tick.
  logic [31:0] tick_cnt_q;

  // Ticks only run while monitoring is on.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (!run_q) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cell evaluation.
  logic [NCT-1:0] cell_op, cell_trip, cell_alm;

  for (genvar g = 0; g < NCT; g++) begin : g_cell
    logic [SW-1:0] sum, avg_q, mag, peak_q, prev_q;
    logic signed [SW:0] dev, step;
    logic [NDET-1:0] use_det;
    logic sign_q;
    logic [7:0] ivl_q, last_q, conf_q, grow_q;
    logic tr_a, tr_p, tr_g;

    assign use_det = det_map_q[g*NDET +: NDET] & ~det_byp_q[g*NDET +: NDET];
    assign cell_op[g] = |use_det;

    // Sum of the mapped, unbypassed detectors of this cell only.
    always_comb begin
      sum = '0;
      for (int d = 0; d < NDET; d++) begin
        if (use_det[d]) begin
          sum = sum + SW'(det_i[g*NDET+d]);
        end
      end
      dev = $signed({1'b0, sum}) - $signed({1'b0, avg_q});
      step = dev >>> FILT_SH;
      mag = dev[SW] ? SW'(-dev) : dev[SW-1:0];
    end

    // Filter, half-period and peak tracking, once per tick.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        avg_q <= '0;
        sign_q <= 1'b0;
        ivl_q <= 8'h00;
        last_q <= 8'h00;
        conf_q <= 8'h00;
        grow_q <= 8'h00;
        peak_q <= '0;
        prev_q <= '0;
      end else if (tick_q) begin
        avg_q <= SW'($signed({1'b0, avg_q}) + step);
        sign_q <= dev[SW];
        if (dev[SW] != sign_q) begin
          // A zero crossing closes one half period.
          if (ivl_q >= 8'(PER_MIN) && ivl_q <= last_q + 8'h01 &&
              ivl_q + 8'h01 >= last_q) begin
            conf_q <= (conf_q == 8'hFF) ? conf_q : conf_q + 8'h01;
          end else begin
            conf_q <= 8'h00;
          end
          if (peak_q > prev_q + (prev_q >> 3)) begin
            grow_q <= (grow_q == 8'hFF) ? grow_q : grow_q + 8'h01;
          end else begin
            grow_q <= 8'h00;
          end
          last_q <= ivl_q;
          ivl_q <= 8'h01;
          prev_q <= peak_q;
          peak_q <= mag;
        end else begin
          ivl_q <= (ivl_q == 8'hFF) ? ivl_q : ivl_q + 8'h01;
          peak_q <= (mag > peak_q) ? mag : peak_q;
        end
      end
    end

    // Three checks against trip and alarm setpoints.
    assign tr_a = mag > SW'(trip_sp_q.amp);
    assign tr_p = conf_q > trip_sp_q.per;
    assign tr_g = grow_q > trip_sp_q.gro;
    assign cell_trip[g] = cell_op[g] & (tr_a | tr_p | tr_g);
    assign cell_alm[g] = cell_op[g] & ((mag > SW'(alm_sp_q.amp)) |
                         (conf_q > alm_sp_q.per) |
                         (grow_q > alm_sp_q.gro));
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel logic.
  logic [NCH-1:0] en_d, ctrip_d, inop_d, pre_d;

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      en_d[c] = (stp_i[c] > POWER_EN_PCT) &&
                (flow_i[c] <= FLOW_EN_PCT);
      ctrip_d[c] = en_d[c] & |cell_trip[c*NCELL +: NCELL];
      pre_d[c] = |cell_alm[c*NCELL +: NCELL];
      inop_d[c] = 8'($countones(cell_op[c*NCELL +: NCELL])) <
                  min_cell_q;
    end
  end

  // Channel status, refreshed on each tick.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrip_q <= 4'h0;
      inop_q <= 4'h0;
      pre_q <= 4'h0;
      en_q <= 4'h0;
    end else if (tick_q) begin
      ctrip_q <= ctrip_d;
      inop_q <= inop_d;
      pre_q <= pre_d;
      en_q <= en_d;
    end
  end

  // Same status to the local indicator and the operator panel.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      local_q <= '0;
      panel_q <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        local_q[c] <= '{ctrip_q[c], inop_q[c], pre_q[c], en_q[c]};
        panel_q[c] <= '{ctrip_q[c], inop_q[c], pre_q[c], en_q[c]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-of-four voters.
  logic [NCH-1:0] osc_act, apm_act;
  logic [2:0] osc_cnt, apm_cnt;

  assign osc_act = ctrip_d & ~byp_q;
  assign apm_act = apm_trip_i & ~byp_q;
  assign osc_cnt = 3'($countones(osc_act));
  assign apm_cnt = 3'($countones(apm_act));

  // Every voter sees every channel; 0 and 1 face system A, 2 and 3 B.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trip_n_q <= TRIP_N_RST;
      half_q <= 4'h0;
    end else if (tick_q) begin
      if (osc_cnt >= 3'h2 || apm_cnt >= 3'h2) begin
        trip_n_q <= 4'h0;
      end else begin
        trip_n_q <= 4'hF;
      end
      half_q <= {NCH{osc_cnt == 3'h1}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts.
  always_comb begin
    ev_set = 16'h0000;
    if (tick_q) begin
      ev_set[EV_TRIP +: NCH] = ctrip_d & ~ctrip_q;
      ev_set[EV_INOP +: NCH] = inop_d & ~inop_q;
      ev_set[EV_PRE +: NCH] = pre_d & ~pre_q;
      ev_set[EV_EN +: NCH] = en_d & ~en_q;
    end
  end

  // Write one to clear; a new event in the same cycle wins.
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~((wr_en && reg_sel(paddr_i) == 4'h2) ?
                       pwdata_i[15:0] : 16'h0000)) | ev_set;
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign trip_n_o = trip_n_q;
  assign half_trip_o = half_q;
  assign local_o = local_q;
  assign panel_o = panel_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_vote_two;
    tick_q && osc_cnt >= 3'h2 |=> trip_n_o == 4'h0;
  endproperty
  a_vote_two: assert property (p_vote_two)
    else $error("two channel trips did not trip all voters");

  property p_half;
    tick_q && osc_cnt == 3'h1 && apm_cnt < 3'h2
      |=> trip_n_o == 4'hF && half_trip_o == 4'hF;
  endproperty
  a_half: assert property (p_half)
    else $error("single channel trip not seen as half trip");

  property p_separate;
    tick_q && osc_cnt == 3'h1 && apm_cnt == 3'h1 |=> trip_n_o == 4'hF;
  endproperty
  a_separate: assert property (p_separate)
    else $error("mixed trips were voted together");

  property p_gate;
    tick_q && (stp_i[0] <= POWER_EN_PCT || flow_i[0] > FLOW_EN_PCT)
      |=> ctrip_q[0] == 1'b0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("channel trip outside enable region");

  property p_bypass;
    tick_q && $countones(byp_q) == 1 && $countones(ctrip_d) == 2 &&
      (ctrip_d & byp_q) != 4'h0 && apm_cnt < 3'h2 |=> trip_n_o == 4'hF;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypassed channel trip still counted in the vote");

  property p_failsafe;
    tick_q && osc_cnt < 3'h2 && apm_cnt < 3'h2 ##1 !tick_q [*2]
      |-> trip_n_o == 4'hF;
  endproperty
  a_failsafe: assert property (p_failsafe)
    else $error("voter deenergized without a vote");

  property p_inop;
    tick_q |=> inop_q == $past(inop_d);
  endproperty
  a_inop: assert property (p_inop)
    else $error("inoperative alarm not updated on tick");

  property p_tick_hold;
    !$past(tick_q) |-> $stable(ctrip_q) && $stable(trip_n_o);
  endproperty
  a_tick_hold: assert property (p_tick_hold)
    else $error("channel state changed between ticks");

  property p_en_alarm;
    $rose(en_q[0]) |-> irq_stat_q[EV_EN];
  endproperty
  a_en_alarm: assert property (p_en_alarm)
    else $error("enable region entry not flagged");

endmodule
`default_nettype wire

/* File: common/otv_pkg.sv */
// Constants, types and register map of the oscillation trip voter.
`default_nettype none
package otv_pkg;
  localparam int NCH = 4;
  localparam int NCELL = 2;
  localparam int NDET = 3;
  localparam int NCT = NCH * NCELL;
  localparam int DW = 12;
  localparam int SW = 14;
  localparam int FILT_SH = 3;
  localparam int PER_MIN = 2;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] POWER_EN_PCT = 8'h1A;
  localparam logic [7:0] FLOW_EN_PCT = 8'h3C;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_TRIPSP = 8'h10;
  localparam logic [7:0] OFS_ALMSP = 8'h14;
  localparam logic [7:0] OFS_MINCELL = 8'h18;
  localparam logic [7:0] OFS_DETMAP = 8'h1C;
  localparam logic [7:0] OFS_DETBYP = 8'h20;
  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_BYP = 4;
  localparam int EV_TRIP = 0;
  localparam int EV_INOP = 4;
  localparam int EV_PRE = 8;
  localparam int EV_EN = 12;
  // Reset values.
  localparam logic [23:0] SP_RST = 24'hFFFFFF;
  localparam logic [23:0] DETMAP_RST = 24'h000000;
  localparam logic [7:0] MINCELL_RST = 8'h01;
  localparam logic [3:0] TRIP_N_RST = 4'h0;
  typedef struct packed {
    logic trip;
    logic inop;
    logic pretrip;
    logic en_alarm;
  } otv_chan_stat_t;
  typedef struct packed {
    logic [7:0] gro;
    logic [7:0] per;
    logic [7:0] amp;
  } otv_sp_t;
endpackage
`default_nettype wire

/* File: tb/otv_relay_model.sv */
// Relay coil model of the protection trip system inputs.
`default_nettype none
module otv_relay_model (
  // Voter drive.
  input wire logic [3:0] coil_i,
  // Relay and trip system state.
  output logic [3:0] relay_open_o,
  output logic [1:0] sys_trip_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A coil without drive drops out, so lost drive reads as a trip.
  assign relay_open_o = ~coil_i;
  // Voters 0 and 1 feed system A, voters 2 and 3 feed system B.
  assign sys_trip_o = {|relay_open_o[3:2], |relay_open_o[1:0]};
endmodule
`default_nettype wire

/* File: tb/oscillation_trip_voter_bench.sv */
// Self-checking bench of the oscillation trip voter.
`default_nettype none
module oscillation_trip_voter_bench import otv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 8;
  typedef struct packed {
    logic [3:0] osc;
    logic [3:0] apm;
    logic [7:0] ctrl;
    logic [7:0] stp;
    logic [7:0] flow;
    logic [32:0] e;
    logic [32:0] m;
    logic [3:0] tn;
  } otv_step_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NCT*NDET-1:0][DW-1:0] det = '0;
  logic [NCH-1:0][7:0] stp = {NCH{8'h1B}};
  logic [NCH-1:0][7:0] flow = {NCH{8'h3C}};
  logic [NCH-1:0] apm = 4'h0;
  logic [NCH-1:0] trip_n;
  logic [NCH-1:0] half;
  otv_chan_stat_t [NCH-1:0] loc;
  otv_chan_stat_t [NCH-1:0] pnl;
  logic irq;
  logic [3:0] relay;
  logic [1:0] sys;
  logic [3:0] osc_on = 4'h0;
  int error_cnt = 0;
  int total_checks = 0;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [32:0] rd_m;
  otv_step_t tbl[10] = '{
    '{4'h0, 4'h0, 8'h01, 8'h1B, 8'h3C, 33'h0, 33'h0FF000F, 4'hF},
    '{4'h1, 4'h0, 8'h01, 8'h1B, 8'h3C, 33'h00F0001, 33'h0FF000F, 4'hF},
    '{4'h1, 4'h4, 8'h01, 8'h1B, 8'h3C, 33'h00F0001, 33'h0FF000F, 4'hF},
    '{4'h3, 4'h4, 8'h01, 8'h1B, 8'h3C, 33'h0F00003, 33'h0FF000F, 4'h0},
    '{4'h3, 4'h4, 8'h21, 8'h1B, 8'h3C, 33'h00F0001, 33'h0FF000D, 4'hF},
    '{4'h3, 4'h4, 8'h21, 8'h1B, 8'h3D, 33'h0, 33'h0FF1001, 4'hF},
    '{4'h3, 4'h4, 8'h21, 8'h1A, 8'h3C, 33'h0, 33'h0FF1001, 4'hF},
    '{4'h3, 4'h4, 8'h21, 8'h1B, 8'h3C, 33'h00F1001, 33'h0FF1001, 4'hF},
    '{4'h3, 4'hC, 8'h21, 8'h1B, 8'h3C, 33'h0FF0001, 33'h0FF000D, 4'h0},
    '{4'h3, 4'h6, 8'h21, 8'h1B, 8'h3C, 33'h00F0001, 33'h0FF000D, 4'hF}
  };

  ////////////////////////////////////////////////////////////////////////////
  // Design, relay model and clock.
  otv_top #(.TICK_CYCLES(TK)) dut (
    .clk_sys_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .det_i(det), .stp_i(stp),
    .flow_i(flow), .apm_trip_i(apm), .trip_n_o(trip_n),
    .half_trip_o(half), .local_o(loc), .panel_o(pnl), .irq_o(irq)
  );
  otv_relay_model relay_model (
    .coil_i(trip_n), .relay_open_o(relay), .sys_trip_o(sys)
  );
  initial begin
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks.
  task automatic chk(input string nm, input logic [32:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One transfer, held until pready is seen, then an idle edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) begin
      error_cnt++;
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data is taken at the edge that completes the read.
  always @(posedge clk) begin
    if (pready === 1'b1 && psel && pen && !pwr && exp_q.size() > 0) begin
      rd_m = msk_q.pop_front();
      chk("read", {pslverr, prdata} & rd_m, exp_q.pop_front());
    end
  end
  // Mapped detectors of oscillating channels swing to a random level.
  // The floor keeps every high sample well clear of the filtered average.
  always begin
    repeat (TK) @(posedge clk);
    for (int g = 0; g < NCT; g++) begin
      det[g*NDET] <= (osc_on[g/NCELL] && det[g*NDET] == '0) ?
        DW'($urandom_range(12'hFFF, 12'hC00)) : '0;
    end
  end
  // Hang guard.
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    void'($urandom(81882));
    repeat (2) @(posedge clk);
    chk("trip_n_rst", 33'(trip_n), 33'h0);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFS_TRIPSP, {9'h0, SP_RST}, '1);
    rd(OFS_MINCELL, {25'h0, MINCELL_RST}, '1);
    rd(OFS_DETMAP, {9'h0, DETMAP_RST}, '1);
    rd(8'h40, {1'b1, 32'h0}, '1);
    apb(1'b1, OFS_DETMAP, 32'h00249249);
    apb(1'b1, OFS_TRIPSP, 32'h00FFFF10);
    apb(1'b1, OFS_ALMSP, 32'h00FFFF10);
    apb(1'b1, OFS_MASK, 32'h000000F0);
    foreach (tbl[i]) begin
      osc_on <= tbl[i].osc;
      apm <= tbl[i].apm;
      stp[0] <= tbl[i].stp;
      flow[0] <= tbl[i].flow;
      apb(1'b1, OFS_CTRL, {24'h0, tbl[i].ctrl});
      ticks(4);
      chk("trip_n", 33'(trip_n), 33'(tbl[i].tn));
      chk("half", 33'(half), 33'(tbl[i].e[19:16]));
      chk("sys_trip", 33'(sys), {31'h0, {2{tbl[i].tn != 4'hF}}});
      rd(OFS_STAT, tbl[i].e, tbl[i].m);
    end
    chk("local", 33'(loc[0]), 33'hB);
    chk("panel", 33'(pnl[0]), 33'hB);
    chk("irq_masked", 33'(irq), 33'h0);
    rd(OFS_IRQ, 33'h0001003, 33'h00010FF);
    apb(1'b1, OFS_MINCELL, 32'h3);
    ticks(3);
    chk("irq_inop", 33'(irq), 33'h1);
    rd(OFS_STAT, 33'hF0, 33'hF0);
    apb(1'b1, OFS_IRQ, 32'h000000F0);
    ticks(1);
    chk("irq_clear", 33'(irq), 33'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
